// ### include/tom_consts.svh
// Purpose: Register indices, field positions, reset values of the trigger OR engine
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only, shared by the package and the engine
`ifndef TOM_CONSTS_SVH
`define TOM_CONSTS_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define TOM_ADDR_W       20

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define TOM_IDX_CAP      18'h09dd0
`define TOM_IDX_SEL      18'h09dda
`define TOM_IDX_CTRL     18'h09e00
`define TOM_IDX_CHLO     18'h09e10
`define TOM_IDX_CHHI     18'h09e11
`define TOM_IDX_DLY      18'h09e20
`define TOM_IDX_ISTAT    18'h09e30
`define TOM_IDX_ICLR     18'h09e31
`define TOM_IDX_IEN      18'h09e32
`define TOM_IDX_STAT     18'h09e40

// ----------------------------------------------------------------------
// Source select encoding
// ----------------------------------------------------------------------
`define TOM_NO_SOURCE    32'h0000_0000
`define TOM_SW_BIT       32'h0000_0001
`define TOM_EXT0_BIT     32'h0000_0002
`define TOM_EXT1_BIT     32'h0000_0004
`define TOM_EXTRA_TTL_INPUT0_BIT     32'h0000_0100
`define TOM_EXTRA_TTL_INPUT1_BIT     32'h0000_0200
`define TOM_SEL_DEFINED  32'h0000_0307
`define TOM_SEL_RESET    32'h0000_0001

// ----------------------------------------------------------------------
// Control and interrupt fields
// ----------------------------------------------------------------------
`define TOM_CTRL_START   0
`define TOM_CTRL_STOP    1
`define TOM_CTRL_FORCE   2
`define TOM_CTRL_EN      3
`define TOM_INT_HIT      0
`define TOM_INT_OUT      1
`define TOM_INT_W        2

`endif

// ### include/tom_pkg.sv
// Purpose: Types of the trigger OR engine
// Assumes: Constants come from the shared header
// Notes:   State is one packed struct per module
`include "tom_consts.svh"

package tom_pkg;

	// ------------------------------------------------------------------
	// APB carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                   psel;
		logic                   penable;
		logic                   pwrite;
		logic [`TOM_ADDR_W-1:0] paddr;
		logic [31:0]            pwdata;
	} tom_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tom_apb_rsp_t;

	// ------------------------------------------------------------------
	// Engine phases and state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		TOM_IDLE  = 3'b001,
		TOM_ARMED = 3'b010,
		TOM_DELAY = 3'b100
	} tom_phase_t;

	typedef struct packed {
		tom_phase_t              phase;
		logic [31:0]             sel;
		logic [31:0]             ch_lo;
		logic [31:0]             ch_hi;
		logic                    trig_en;
		logic [31:0]             delay;
		logic [31:0]             dcnt;
		logic [`TOM_INT_W-1:0]   ist;
		logic [`TOM_INT_W-1:0]   ien;
		logic                    irq;
		logic                    trig;
		tom_apb_rsp_t            rsp;
	} tom_state_t;

endpackage

// ### rtl/tom_engine.sv
// Purpose: Trigger OR mask engine with APB registers, delay stage and interrupt
// Assumes: One core_clk at 250 MHz; channel detectors run on core_clk
// Notes:   Pin triggers are synchronised, costing two cycles of latency
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tom_consts.svh"

// Operation
// - The OR combination has a general part for software and external pins and a channel part.
// - A read/write source select register chooses which general sources take part.
// - A read-only capability register shows a set bit for each source present on the card.
// - Select bits are 0 none, 1h software, 2h ext 0, 4h ext 1, 100h extra 0, 200h extra 1.
// - With the software bit selected the trigger rises as soon as the engine is armed.
// - With an external bit selected the trigger rises once that input condition is valid.
// - External 1 and the extra inputs exist only on some variants and read as zero if absent.
// - After reset the select register holds only the software bit, which software should clear.
// - One enable command switches every trigger source on or off at once.
// - A force command while armed gives a trigger whatever the masks hold.
// - The combined event passes a programmable delay before the final trigger goes out.
// - All sources reach the OR, but only those with a select bit set are recognised.
// - Channel sources use two channel select registers and exist only on acquisition cards.
module tom_engine #(
	parameter int NUM_CH   = 64,
	parameter bit IS_ACQ   = 1'b1,
	parameter bit HAS_EXT1 = 1'b0,
	parameter bit HAS_XIO  = 1'b0
)(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	// APB slave
	input  wire tom_pkg::tom_apb_req_t apb_req,
	output var  tom_pkg::tom_apb_rsp_t apb_rsp,
	// Trigger pins
	input  wire logic                  external_input0,
	input  wire logic                  external_input1,
	input  wire logic                  extra_ttl_input0,
	input  wire logic                  extra_ttl_input1,
	// Channel detectors
	input  wire logic [NUM_CH-1:0]     chan_detect,
	// Results
	output logic                       trig_out,
	output logic                       armed,
	output logic                       irq
);
	import tom_pkg::*;

	// ------------------------------------------------------------------
	// Variant constants
	// ------------------------------------------------------------------
	localparam logic [63:0] CH_ONES  = (NUM_CH >= 64) ? 64'hffff_ffff_ffff_ffff :
	                                   ((64'h1 << NUM_CH) - 64'h1);
	// Channel detectors only count on acquisition cards
	localparam logic [63:0] CH_AVAIL = IS_ACQ ? CH_ONES : 64'h0;

	if (NUM_CH < 1 || NUM_CH > 64)
	begin : g_param_check
		$error("tom_engine serves 1 to 64 channel detectors");
	end

	tom_state_t  st;
	tom_state_t  next_st;
	logic [3:0]  pins;
	logic [31:0] cap_val;
	logic [31:0] src_vec;
	logic [63:0] ch_sel;
	logic [31:0] rd_data;
	logic        mapped;
	logic        acc;
	logic        wr_go;
	logic        is_cap;
	logic        is_sel;
	logic        is_ctrl;
	logic        is_chlo;
	logic        is_chhi;
	logic        is_dly;
	logic        is_istat;
	logic        is_iclr;
	logic        is_ien;
	logic        is_stat;
	logic        start_cmd;
	logic        stop_cmd;
	logic        force_cmd;
	logic        gen_hit;
	logic        ch_hit;
	logic        hit;
	logic        fire;

	// ------------------------------------------------------------------
	// Source conditioning
	// ------------------------------------------------------------------
	// Pins are asynchronous, so every one passes two flops first
	tom_sync #(
		.WIDTH    (4)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in ({extra_ttl_input1, extra_ttl_input0, external_input1, external_input0}),
		.sync_out (pins)
	);

	assign cap_val = `TOM_SW_BIT | `TOM_EXT0_BIT
	               | (HAS_EXT1 ? `TOM_EXT1_BIT : `TOM_NO_SOURCE)
	               | (HAS_XIO ? (`TOM_EXTRA_TTL_INPUT0_BIT | `TOM_EXTRA_TTL_INPUT1_BIT) : `TOM_NO_SOURCE);

	// Source bit placement
	// Software source is always asserted; it only counts once armed
	assign src_vec = `TOM_SW_BIT
	               | ({32{pins[0]}} & `TOM_EXT0_BIT)
	               | ({32{pins[1]}} & `TOM_EXT1_BIT)
	               | ({32{pins[2]}} & `TOM_EXTRA_TTL_INPUT0_BIT)
	               | ({32{pins[3]}} & `TOM_EXTRA_TTL_INPUT1_BIT);

	// General part and channel part of the OR
	// Only selected and present sources count
	assign gen_hit = |(st.sel & cap_val & src_vec);
	// Channel part over both channel select words
	assign ch_sel  = {st.ch_hi, st.ch_lo};
	assign ch_hit  = |(ch_sel[NUM_CH-1:0] & CH_AVAIL[NUM_CH-1:0] & chan_detect);
	assign hit     = gen_hit | ch_hit;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign acc      = apb_req.psel & apb_req.penable;
	assign is_cap   = apb_req.paddr == {`TOM_IDX_CAP, 2'b00};
	assign is_sel   = apb_req.paddr == {`TOM_IDX_SEL, 2'b00};
	assign is_ctrl  = apb_req.paddr == {`TOM_IDX_CTRL, 2'b00};
	assign is_chlo  = apb_req.paddr == {`TOM_IDX_CHLO, 2'b00};
	assign is_chhi  = apb_req.paddr == {`TOM_IDX_CHHI, 2'b00};
	assign is_dly   = apb_req.paddr == {`TOM_IDX_DLY, 2'b00};
	assign is_istat = apb_req.paddr == {`TOM_IDX_ISTAT, 2'b00};
	assign is_iclr  = apb_req.paddr == {`TOM_IDX_ICLR, 2'b00};
	assign is_ien   = apb_req.paddr == {`TOM_IDX_IEN, 2'b00};
	assign is_stat  = apb_req.paddr == {`TOM_IDX_STAT, 2'b00};
	assign mapped   = is_cap | is_sel | is_ctrl | is_chlo | is_chhi | is_dly
	                | is_istat | is_iclr | is_ien | is_stat;

	// Writes land only on the edge that samples pready high
	assign wr_go     = acc & apb_req.pwrite & st.rsp.pready & mapped;
	assign start_cmd = wr_go & is_ctrl & apb_req.pwdata[`TOM_CTRL_START];
	assign stop_cmd  = wr_go & is_ctrl & apb_req.pwdata[`TOM_CTRL_STOP];
	assign force_cmd = wr_go & is_ctrl & apb_req.pwdata[`TOM_CTRL_FORCE];

	// Read mux; write-only and command bits read as zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (is_cap)
			rd_data = cap_val;
		if (is_sel)
			rd_data = st.sel;
		if (is_ctrl)
			rd_data[`TOM_CTRL_EN] = st.trig_en;
		if (is_chlo)
			rd_data = st.ch_lo;
		if (is_chhi)
			rd_data = st.ch_hi;
		if (is_dly)
			rd_data = st.delay;
		if (is_istat)
			rd_data[`TOM_INT_W-1:0] = st.ist;
		if (is_ien)
			rd_data[`TOM_INT_W-1:0] = st.ien;
		if (is_stat)
			rd_data[2:0] = st.phase;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_st      = st;
		next_st.trig = 1'b0;
		fire         = 1'b0;
		// One wait state keeps the read mux off the output path
		next_st.rsp.pready = acc & ~st.rsp.pready;
		if (acc && !st.rsp.pready)
		begin
			next_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_data;
			next_st.rsp.pslverr = ~mapped;
		end
		// Register writes
		if (wr_go)
		begin
			if (is_sel)
				next_st.sel = apb_req.pwdata & `TOM_SEL_DEFINED;
			// Channel select words, absent channels stay zero
			if (is_chlo)
				next_st.ch_lo = apb_req.pwdata & CH_AVAIL[31:0];
			if (is_chhi)
				next_st.ch_hi = apb_req.pwdata & CH_AVAIL[63:32];
			if (is_ctrl)
				next_st.trig_en = apb_req.pwdata[`TOM_CTRL_EN];
			if (is_dly)
				next_st.delay = apb_req.pwdata;
			if (is_ien)
				next_st.ien = apb_req.pwdata[`TOM_INT_W-1:0];
			if (is_iclr)
				next_st.ist = st.ist & ~apb_req.pwdata[`TOM_INT_W-1:0];
		end
		// Phase machine; stop wins over every other command
		unique case (st.phase)
			TOM_IDLE:
			begin
				if (start_cmd && !stop_cmd)
					next_st.phase = TOM_ARMED;
			end
			TOM_ARMED:
			begin
				if (stop_cmd)
					next_st.phase = TOM_IDLE;
				// Software and pin sources fire through hit
				else if (force_cmd || (st.trig_en && hit))
				begin
					fire = 1'b1;
					// Zero delay issues on the next edge
					if (st.delay == 32'h0000_0000)
					begin
						next_st.trig  = 1'b1;
						next_st.phase = TOM_IDLE;
					end
					else
					begin
						next_st.dcnt  = st.delay;
						next_st.phase = TOM_DELAY;
					end
				end
			end
			TOM_DELAY:
			begin
				if (stop_cmd)
					next_st.phase = TOM_IDLE;
				else if (st.dcnt == 32'h0000_0001)
				begin
					next_st.trig  = 1'b1;
					next_st.phase = TOM_IDLE;
				end
				else
					next_st.dcnt = st.dcnt - 32'h0000_0001;
			end
		endcase
		// Sticky events; a set in the clear cycle wins
		if (fire)
			next_st.ist[`TOM_INT_HIT] = 1'b1;
		if (next_st.trig)
			next_st.ist[`TOM_INT_OUT] = 1'b1;
		next_st.irq = |(next_st.ist & next_st.ien);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st       <= '0;
			st.phase <= TOM_IDLE;
			st.sel   <= `TOM_SEL_RESET;
		end
		else
			st <= next_st;
	end

	assign apb_rsp  = st.rsp;
	assign trig_out = st.trig;
	assign armed    = st.phase[1]; // One-hot armed bit, straight from its flop
	assign irq      = st.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sel_reset_a:
	assert property ($rose(resetn) |-> st.sel == `TOM_SEL_RESET)
	else $error("select register not at reset value");

	cap_read_a:
	assert property (acc && !st.rsp.pready && is_cap && !apb_req.pwrite
	                 |=> apb_rsp.pready && apb_rsp.prdata == cap_val && !apb_rsp.pslverr)
	else $error("capability read returned wrong data");

	cap_absent_a:
	assert property (cap_val[2] == HAS_EXT1 && cap_val[8] == HAS_XIO && cap_val[9] == HAS_XIO)
	else $error("capability shows an absent source");

	sw_fire_a:
	assert property (st.phase == TOM_ARMED && st.trig_en && st.sel[0] && !stop_cmd
	                 |=> st.phase == TOM_DELAY || (trig_out && st.phase == TOM_IDLE))
	else $error("software source did not fire");

	force_fire_a:
	assert property (st.phase == TOM_ARMED && force_cmd && !stop_cmd
	                 |=> st.phase != TOM_ARMED && st.ist[`TOM_INT_HIT])
	else $error("force did not fire");

	enable_gate_a:
	assert property (st.phase == TOM_ARMED && !st.trig_en && !force_cmd
	                 |=> !trig_out && st.phase != TOM_DELAY)
	else $error("disabled engine fired");

	mask_gate_a:
	assert property (st.phase == TOM_ARMED && !hit && !force_cmd
	                 |=> !trig_out && st.phase != TOM_DELAY)
	else $error("unselected source fired");

	first_hit_a:
	assert property (st.phase == TOM_ARMED && st.trig_en && hit && !stop_cmd
	                 |=> st.phase == TOM_DELAY || trig_out)
	else $error("enabled hit missed");

	delay_len_a:
	assert property (fire && st.delay != 32'h0000_0000 && !stop_cmd
	                 |=> st.phase == TOM_DELAY && st.dcnt == $past(st.delay) && !trig_out)
	else $error("delay stage not loaded with programmed delay");

	delay_end_a:
	assert property (st.phase == TOM_DELAY && st.dcnt == 32'h0000_0001 && !stop_cmd
	                 |=> trig_out && st.phase == TOM_IDLE)
	else $error("delay end did not issue the trigger");

	trig_pulse_a:
	assert property (trig_out |-> $past(st.phase) != TOM_IDLE ##1 !trig_out)
	else $error("trigger output longer than one cycle");

endmodule // tom_engine

`default_nettype wire

// ### rtl/tom_sync.sv
// Purpose: Two-stage synchroniser for the external trigger pins
// Assumes: Pins are asynchronous to core_clk
// Notes:   The first stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none

module tom_sync #(
	parameter int WIDTH = 4
)(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} tom_sync_state_t;

	tom_sync_state_t st;
	tom_sync_state_t next_st;

	// Elaboration check on the width
	if (WIDTH < 1)
	begin : g_width_check
		$error("tom_sync needs WIDTH of at least one");
	end

	// Shift pins through both stages
	always_comb
	begin
		next_st      = st;
		next_st.meta = async_in;
		next_st.held = st.meta;
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_out = st.held;

endmodule // tom_sync

`default_nettype wire

// ### tb/tom_host_model.sv
// Purpose: Host driver and trigger pin model for the trigger OR engine
// Assumes: Host speaks APB, changing signals just after core_clk rises
// Notes:   Pins idle low; a low pin is no trigger condition
`timescale 1ns/100ps
`default_nettype none

module tom_host_model (
	// Clock
	input  wire logic                  core_clk,
	// APB master side
	output var  tom_pkg::tom_apb_req_t apb_req,
	input  wire tom_pkg::tom_apb_rsp_t apb_rsp,
	// Trigger pins: ext 0, ext 1, extra 0, extra 1
	output logic [3:0]                 pins
);
	import tom_pkg::*;

	// ------------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------------
	initial apb_req = '0;
	initial pins = 4'h0;

	// One transfer, held until pready is seen at a rising edge; one idle
	// cycle after it so a caller never reassigns the request in one step
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do
			@(posedge core_clk);
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge core_clk);
	endtask

	// Pin levels change only right after a clock edge
	task automatic set_pins(input logic [3:0] v);
		pins <= v;
	endtask
endmodule // tom_host_model

`default_nettype wire

// ### tb/trigger_or_mask_engine_tb.sv
// Purpose: Self-checking bench of the trigger OR engine
// Assumes: Card with ext input 1, without the extra TTL inputs
// Notes:   Register model is an associative array of expected words
`timescale 1ns/100ps
`default_nettype none
`include "tom_consts.svh"

module trigger_or_mask_engine_tb;
	import tom_pkg::*;

	// ------------------------------------------------------------------
	// Signals and model
	// ------------------------------------------------------------------
	localparam logic [19:0] A_CAP = {`TOM_IDX_CAP, 2'b00};
	localparam logic [19:0] A_SEL = {`TOM_IDX_SEL, 2'b00};
	localparam logic [19:0] A_CTRL = {`TOM_IDX_CTRL, 2'b00};
	localparam logic [19:0] A_CHHI = {`TOM_IDX_CHHI, 2'b00};
	localparam logic [19:0] A_DLY = {`TOM_IDX_DLY, 2'b00};
	localparam logic [19:0] A_ISTAT = {`TOM_IDX_ISTAT, 2'b00};
	localparam logic [19:0] A_ICLR = {`TOM_IDX_ICLR, 2'b00};
	localparam logic [19:0] A_IEN = {`TOM_IDX_IEN, 2'b00};
	logic         core_clk;
	logic         resetn;
	tom_apb_req_t apb_req;
	tom_apb_rsp_t apb_rsp;
	logic [3:0]   pins;
	logic [63:0]  chan_detect;
	logic         trig_out;
	logic         armed;
	logic         irq;
	logic [31:0]  rd;
	logic         err;
	logic [31:0]  lf;
	logic [31:0]  mdl [logic [19:0]];
	logic [31:0]  pbit [4] = '{32'h2, 32'h4, 32'h100, 32'h200};
	int           mismatches = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int           dly;

	tom_host_model i_host (
		.core_clk (core_clk),
		.apb_req  (apb_req),
		.apb_rsp  (apb_rsp),
		.pins     (pins)
	);

	tom_engine #(.NUM_CH(64), .IS_ACQ(1'b1), .HAS_EXT1(1'b1), .HAS_XIO(1'b0)) i_dut (
		.core_clk         (core_clk),
		.resetn           (resetn),
		.apb_req          (apb_req),
		.apb_rsp          (apb_rsp),
		.external_input0  (pins[0]),
		.external_input1  (pins[1]),
		.extra_ttl_input0 (pins[2]),
		.extra_ttl_input1 (pins[3]),
		.chan_detect      (chan_detect),
		.trig_out         (trig_out),
		.armed            (armed),
		.irq              (irq)
	);

	// ------------------------------------------------------------------
	// Clock, timeout, helpers
	// ------------------------------------------------------------------
	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	// Ceiling well above the roughly 600 cycles the sequence needs
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Writable bits per register; others keep their modelled value
	function automatic logic [31:0] wmask(logic [19:0] a);
		case (a)
			A_SEL: return 32'h0000_0307;
			A_CHHI, A_DLY: return 32'hffff_ffff;
			A_IEN: return 32'h0000_0003;
			default: return 32'h0;
		endcase
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd, err);
		mdl[a] = (d & wmask(a)) | (mdl[a] & ~wmask(a));
	endtask

	task automatic rdchk(input logic [19:0] a, input string what);
		i_host.xfer(1'b0, a, '0, rd, err);
		check(what, rd, mdl[a]);
	endtask

	// Control write, then wait a bounded time for the one-cycle trigger
	task automatic run(input logic [31:0] ctl, input logic want, input int lat);
		int n;
		n = 0;
		wr(A_CTRL, ctl);
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (trig_out !== 1'b1 && n < 30);
		check("trig", {31'h0, trig_out}, {31'h0, want});
		if (want && lat > 0)
			check("latency", 32'(n), 32'(lat));
	endtask

	task automatic irqchk(input logic want);
		@(posedge core_clk);
		check("irq", {31'h0, irq}, {31'h0, want});
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		resetn = 1'b0;
		chan_detect = '0;
		lf = 32'd73;
		foreach (pbit[i])
			mdl[20'(i)] = '0;
		mdl[A_CAP] = 32'h7;
		mdl[A_SEL] = 32'h1;
		mdl[A_CTRL] = '0;
		mdl[A_CHHI] = '0;
		mdl[A_DLY] = '0;
		mdl[A_ICLR] = '0;
		mdl[A_IEN] = '0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdchk(A_SEL, "sel_reset");
		rdchk(A_CAP, "capability");
		wr(A_CAP, 32'hffff_ffff);
		rdchk(A_CAP, "capability_ro");
		i_host.xfer(1'b0, 20'h00004, '0, rd, err);
		check("unmapped", {31'h0, err}, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			lf = lfsr_next(lf);
			wr(A_SEL, lf);
			rdchk(A_SEL, "sel_random");
		end
		// Software source with a random delay, interrupt enabled
		dly = int'(lf[2:0]) + 1;
		wr(A_DLY, 32'(dly));
		wr(A_IEN, 32'h3);
		wr(A_SEL, 32'h1);
		run(32'h9, 1'b1, dly + 1);
		mdl[A_ISTAT] = 32'h3;
		rdchk(A_ISTAT, "status");
		irqchk(1'b1);
		wr(A_IEN, 32'h0);
		irqchk(1'b0);
		wr(A_IEN, 32'h3);
		irqchk(1'b1);
		wr(A_ICLR, 32'h3);
		mdl[A_ISTAT] = 32'h0;
		rdchk(A_ISTAT, "status_clear");
		rdchk(A_ICLR, "clear_reads_zero");
		irqchk(1'b0);
		// Enable off holds the software source back, force still fires
		run(32'h1, 1'b0, 0);
		check("armed", {31'h0, armed}, 32'h1);
		run(32'h4, 1'b1, 0);
		run(32'h4, 1'b0, 0);
		check("idle", {31'h0, armed}, 32'h0);
		// Each pin: others high are ignored, own pin fires if fitted
		for (int p = 0; p < 4; p++)
		begin
			i_host.set_pins(4'hf ^ (4'h1 << p));
			wr(A_SEL, pbit[p]);
			run(32'h9, 1'b0, 0);
			wr(A_CTRL, 32'h2);
			i_host.set_pins(4'h1 << p);
			run(32'h9, p < 2, dly + 1);
			wr(A_CTRL, 32'h2);
		end
		// Channel part of the OR, software source cleared first
		i_host.set_pins(4'hf);
		wr(A_SEL, 32'h0);
		wr(A_CHHI, 32'h1 << lf[4:0]);
		chan_detect <= 64'h1 << (32 + lf[4:0]);
		run(32'h9, 1'b1, dly + 1);
		chan_detect <= ~(64'h1 << (32 + lf[4:0]));
		run(32'h9, 1'b0, 0);
		wr(A_CTRL, 32'h2);
		// Stop in the delay stage aborts without a trigger
		wr(A_SEL, 32'h1);
		wr(A_CTRL, 32'h9);
		wr(A_CTRL, 32'h2);
		run(32'h0, 1'b0, 0);
		check("abort_idle", {31'h0, armed}, 32'h0);
		report_and_stop();
	end
endmodule // trigger_or_mask_engine_tb

`default_nettype wire
